/* File: hdl/scb_regs.sv */
// system clock configuration register bank with avalon-mm slave
//
// Function
// - three digital_loop_3 interrupt mask bytes with the digital_loop_0 layout.
// - each digital_loop_3 mask bit resets like its digital_loop_0 twin.
// - a multipurpose_pins drive bit of 0 (reset) gives high drive, 1 low.
// - bit 2 of the second pad register sets serial data pin drive alike.
// - the feedback divider is 8 bits, resets to zero, legal 4 to 255.
// - bit 3 enables the crystal_amplifier (reset), clear takes an oscillator.
// - the input_prescaler code 00/01/10/11 divides by 1/2/4/8, reset 00.
// - bit 0 enables the input_frequency_doubler, reset off, for 50% duty only.
// - reference frequency in hertz is 28 bits over four bytes, low byte first.
// the stability timer.
`timescale 1ns/1ps
module scb_regs
	import scb_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [1:0]  avs_response,
	output logic      [23:0] loop3_irq_mask,
	output logic      [7:0]  mp_drive_low,
	output logic             sdio_drive_low,
	output logic      [7:0]  pll_fb_div,
	output logic             crystal_amplifier_amp_en,
	output logic      [1:0]  prescale_code,
	output logic      [3:0]  prescale_ratio,
	output logic             doubler_en,
	output logic      [27:0] ref_freq_hz,
	output logic             stab_restart,
	output logic             irq
);

	// bus side
	logic                 wait_r;
	logic [31:0]          rdata_r;
	logic [1:0]           resp_r;
	logic [9:0]           idx;
	logic                 req;
	logic                 acc;
	logic                 wr_ok;
	logic                 hit_upd;
	logic                 hit_stat;
	logic [SCB_NREG-1:0]  hit;
	logic [7:0]           rd_nxt;
	logic [1:0]           resp_nxt;

	// storage
	logic [SCB_NREG*8-1:0] shadow_flat;
	logic                  upd_go;
	logic                  stab_r;
	logic [3:0]            ratio_r;

	// applied settings
	logic [23:0]           lmask_r;
	logic [7:0]            mp_drv_r;
	logic                  ser_drv_r;
	logic [7:0]            fbdiv_r;
	logic                  crystal_amplifier_r;
	logic [1:0]            presc_r;
	logic                  dbl_r;
	logic [27:0]           freq_r;

	// events
	logic [SCB_NEVT-1:0]   evt;
	logic [SCB_NEVT-1:0]   stat_clr;
	logic [SCB_NEVT-1:0]   status;
	logic                  rsvd_wr;
	logic [7:0]            imask;
	logic [7:0]            fbdiv_pend;

	// accept falls in the answer cycle, so a held request counts once
	assign idx      = avs_address[11:2];
	assign req      = avs_read | avs_write;
	assign acc      = ~wait_r & req;
	assign wr_ok    = acc & avs_write & avs_byteenable[0];
	// update and status sit outside the stored bank
	assign hit_upd  = (idx == SCB_IDX_UPDATE);
	assign hit_stat = (idx == SCB_IDX_STATUS);

	// update command
	assign upd_go = wr_ok & hit_upd & (avs_writedata[7:0] == SCB_UPD_GO);

	genvar g;
	generate
		for (g = 0; g < SCB_NREG; g++)
		begin : g_reg
			logic [7:0] sh_r;

			// entry match on the word index
			assign hit[g] = (idx == SCB_REG_IDX[g]);

			// written value; reserved bits forced to zero
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					sh_r <= SCB_REG_RST[g];
				else if (wr_ok && hit[g])
					sh_r <= avs_writedata[7:0] & SCB_REG_WMASK[g];
			end

			assign shadow_flat[g*8 +: 8] = sh_r;
		end
	endgenerate

	// read mux and decode
	always_comb
	begin
		rd_nxt   = 8'h00;
		resp_nxt = SCB_RESP_OK;
		if (hit_stat)
			rd_nxt = {{(8-SCB_NEVT){1'b0}}, status};
		else if (hit_upd)
			rd_nxt = 8'h00;
		else if (|hit)
		begin
			for (int i = 0; i < SCB_NREG; i++)
			begin
				if (hit[i])
					rd_nxt = shadow_flat[i*8 +: 8];
			end
		end
		else
			resp_nxt = SCB_RESP_DECERR;
	end

	// one wait cycle, answer stands for the accepting edge
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			wait_r <= 1'b1;
		else if (wait_r && req)
			wait_r <= 1'b0;
		else
			wait_r <= 1'b1;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			rdata_r <= 32'h0000_0000;
		else if (wait_r && avs_read)
			rdata_r <= {24'h00_0000, rd_nxt};
		else if (!wait_r)
			rdata_r <= 32'h0000_0000;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			resp_r <= SCB_RESP_OK;
		else if (wait_r && req)
			resp_r <= resp_nxt;
		else if (!wait_r)
			resp_r <= SCB_RESP_OK;
	end

	assign avs_readdata    = rdata_r;
	assign avs_waitrequest = wait_r;
	assign avs_response    = resp_r;

	// reading status clears only the bits that were returned
	always_comb
	begin
		stat_clr = '0;
		if (acc && avs_read && hit_stat)
			stat_clr = rdata_r[SCB_NEVT-1:0];
	end

	// write that tried to set a reserved bit
	always_comb
	begin
		rsvd_wr = 1'b0;
		for (int i = 0; i < SCB_NREG; i++)
		begin
			if (hit[i] && ((avs_writedata[7:0] & ~SCB_REG_WMASK[i]) != 8'h00))
				rsvd_wr = wr_ok;
		end
	end

	// events: update applied, divider below range, reserved write
	assign fbdiv_pend = shadow_flat[SCB_E_FBDIV*8 +: 8];

	always_comb
	begin
		evt                = '0;
		evt[SCB_EV_UPDATE] = upd_go;
		evt[SCB_EV_FBDIV]  = upd_go & (fbdiv_pend < SCB_FBDIV_MIN);
		evt[SCB_EV_RSVD]   = rsvd_wr;
	end

	// mask acts at once, it does not wait for the update command
	assign imask = shadow_flat[SCB_E_IMASK*8 +: 8];

	scb_irq u_irq
	(
		.core_clk (core_clk),
		.rst      (rst),
		.evt      (evt),
		.clr      (stat_clr),
		.mask     (imask[SCB_NEVT-1:0]),
		.status   (status),
		.irq      (irq)
	);

	// stability timer restart pulse
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			stab_r <= 1'b0;
		else
			stab_r <= upd_go;
	end

	assign stab_restart = stab_r;

	// division ratio of the applied prescaler code
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ratio_r <= 4'h1;
		else
		begin
			case (scb_presc_t'(presc_r))
				SCB_PRE_DIV1: ratio_r <= 4'h1;
				SCB_PRE_DIV2: ratio_r <= 4'h2;
				SCB_PRE_DIV4: ratio_r <= 4'h4;
				SCB_PRE_DIV8: ratio_r <= 4'h8;
				default:      ratio_r <= 4'h1;
			endcase
		end
	end

	assign prescale_ratio = ratio_r;

	// applied settings, copied from the shadow bytes on update
	// so a half-written set never reaches the clock front end
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			lmask_r <= {SCB_REG_RST[SCB_E_LMASK_C],
				SCB_REG_RST[SCB_E_LMASK_B],
				SCB_REG_RST[SCB_E_LMASK_A]};
		else if (upd_go)
			lmask_r <= shadow_flat[SCB_E_LMASK_A*8 +: 24];
	end

	// multipurpose_pins drive, 1 selects low drive
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			mp_drv_r <= SCB_REG_RST[SCB_E_PAD_MP];
		else if (upd_go)
			mp_drv_r <= shadow_flat[SCB_E_PAD_MP*8 +: 8];
	end

	// serial data pin drive, same encoding
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			ser_drv_r <=
				SCB_REG_RST[SCB_E_PAD_SER][SCB_SER_DRV_BIT];
		else if (upd_go)
			ser_drv_r <=
				shadow_flat[SCB_E_PAD_SER*8 + SCB_SER_DRV_BIT];
	end

	// feedback divider; an out-of-range value is still applied
	// and only flagged in status
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			fbdiv_r <= SCB_REG_RST[SCB_E_FBDIV];
		else if (upd_go)
			fbdiv_r <= shadow_flat[SCB_E_FBDIV*8 +: 8];
	end

	// crystal_amplifier enable
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			crystal_amplifier_r <= SCB_REG_RST[SCB_E_SYSCFG][SCB_CRYSTAL_AMPLIFIER_BIT];
		else if (upd_go)
			crystal_amplifier_r <= shadow_flat[SCB_E_SYSCFG*8 + SCB_CRYSTAL_AMPLIFIER_BIT];
	end

	// input_prescaler code
	// ratio output follows one cycle later
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			presc_r <=
				SCB_REG_RST[SCB_E_SYSCFG][SCB_PRESC_LSB +: 2];
		else if (upd_go)
			presc_r <=
				shadow_flat[SCB_E_SYSCFG*8 + SCB_PRESC_LSB +: 2];
	end

	// input_frequency_doubler enable
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			dbl_r <= SCB_REG_RST[SCB_E_SYSCFG][SCB_DOUBLER_BIT];
		else if (upd_go)
			dbl_r <= shadow_flat[SCB_E_SYSCFG*8 + SCB_DOUBLER_BIT];
	end

	// reference frequency; the top byte keeps bits 3:0 only
	// all four bytes move together, so the value never tears
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			freq_r <= {SCB_REG_RST[SCB_E_FREQ3][SCB_FREQ3_W-1:0],
				SCB_REG_RST[SCB_E_FREQ2],
				SCB_REG_RST[SCB_E_FREQ1],
				SCB_REG_RST[SCB_E_FREQ0]};
		else if (upd_go)
			freq_r <= {shadow_flat[SCB_E_FREQ3*8 +: SCB_FREQ3_W],
				shadow_flat[SCB_E_FREQ2*8 +: 8],
				shadow_flat[SCB_E_FREQ1*8 +: 8],
				shadow_flat[SCB_E_FREQ0*8 +: 8]};
	end

	// applied settings out to the clock front end
	assign loop3_irq_mask = lmask_r;
	assign mp_drive_low   = mp_drv_r;
	assign sdio_drive_low = ser_drv_r;
	assign pll_fb_div     = fbdiv_r;
	assign crystal_amplifier_amp_en    = crystal_amplifier_r;
	assign prescale_code  = presc_r;
	assign doubler_en     = dbl_r;
	assign ref_freq_hz    = freq_r;

endmodule

/* File: hdl/scb_pkg.sv */
// shared constants for the system clock configuration register bank
package scb_pkg;

	// register entries held in the bank
	localparam int SCB_NREG = 12;
	localparam int SCB_NEVT = 3;

	// entry numbers
	localparam int SCB_E_LMASK_A = 0;
	localparam int SCB_E_LMASK_B = 1;
	localparam int SCB_E_LMASK_C = 2;
	localparam int SCB_E_PAD_MP  = 3;
	localparam int SCB_E_PAD_SER = 4;
	localparam int SCB_E_FBDIV   = 5;
	localparam int SCB_E_SYSCFG  = 6;
	localparam int SCB_E_FREQ0   = 7;
	localparam int SCB_E_FREQ1   = 8;
	localparam int SCB_E_FREQ2   = 9;
	localparam int SCB_E_FREQ3   = 10;
	localparam int SCB_E_IMASK   = 11;

	// register index; byte address is four times the index
	localparam logic [9:0] SCB_IDX_UPDATE = 10'h00f;
	localparam logic [9:0] SCB_IDX_STATUS = 10'h0f0;
	localparam logic [9:0] SCB_REG_IDX [SCB_NREG] = '{
		10'h11b, 10'h11c, 10'h11d, 10'h11e, 10'h11f, 10'h200,
		10'h201, 10'h202, 10'h203, 10'h204, 10'h205, 10'h0f1};

	// digital_loop_0 mask defaults, copied for digital_loop_3
	localparam logic [7:0] SCB_LOOP_MASK_A_RST = 8'h00;
	localparam logic [7:0] SCB_LOOP_MASK_B_RST = 8'h00;
	localparam logic [7:0] SCB_LOOP_MASK_C_RST = 8'h00;

	// writable bits; all others are reserved
	localparam logic [7:0] SCB_REG_WMASK [SCB_NREG] = '{
		8'hff, 8'hff, 8'hff, 8'hef, 8'h04, 8'hff,
		8'h0f, 8'hff, 8'hff, 8'hff, 8'h0f, 8'h07};

	localparam logic [7:0] SCB_REG_RST [SCB_NREG] = '{
		SCB_LOOP_MASK_A_RST, SCB_LOOP_MASK_B_RST, SCB_LOOP_MASK_C_RST,
		8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	// field positions
	localparam int SCB_SER_DRV_BIT  = 2;
	localparam int SCB_CRYSTAL_AMPLIFIER_BIT     = 3;
	localparam int SCB_PRESC_LSB    = 1;
	localparam int SCB_DOUBLER_BIT  = 0;
	localparam int SCB_FREQ3_W      = 4;

	// feedback divider legal range
	localparam logic [7:0] SCB_FBDIV_MIN = 8'h04;

	// update command value
	localparam logic [7:0] SCB_UPD_GO = 8'h01;

	// event bits
	localparam int SCB_EV_UPDATE = 0;
	localparam int SCB_EV_FBDIV  = 1;
	localparam int SCB_EV_RSVD   = 2;

	// avalon response codes
	localparam logic [1:0] SCB_RESP_OK     = 2'h0;
	localparam logic [1:0] SCB_RESP_DECERR = 2'h3;

	// prescaler codes
	typedef enum logic [1:0] {
		SCB_PRE_DIV1 = 2'b00,
		SCB_PRE_DIV2 = 2'b01,
		SCB_PRE_DIV4 = 2'b10,
		SCB_PRE_DIV8 = 2'b11
	} scb_presc_t;

endpackage

/* File: hdl/scb_irq.sv */
// sticky event status, mask gating and level interrupt
`timescale 1ns/1ps
module scb_irq
	import scb_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic [SCB_NEVT-1:0] evt,
	input  wire logic [SCB_NEVT-1:0] clr,
	input  wire logic [SCB_NEVT-1:0] mask,
	output logic      [SCB_NEVT-1:0] status,
	output logic                     irq
);

	logic [SCB_NEVT-1:0] status_r;
	logic                irq_r;

	genvar g;
	generate
		for (g = 0; g < SCB_NEVT; g++)
		begin : g_bit
			// set wins over a read clear in the same cycle
			always_ff @(posedge core_clk or posedge rst)
			begin
				if (rst)
					status_r[g] <= 1'b0;
				else if (evt[g])
					status_r[g] <= 1'b1;
				else if (clr[g])
					status_r[g] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_r & mask);
	end

	assign status = status_r;
	assign irq    = irq_r;

endmodule

/* File: verification/scb_regs_properties.sv */
// port assertions for the register bank
`timescale 1ns/1ps
module scb_regs_properties
	import scb_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic [11:0] avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [1:0]  avs_response,
	input wire logic [23:0] loop3_irq_mask,
	input wire logic [7:0]  mp_drive_low,
	input wire logic        sdio_drive_low,
	input wire logic [7:0]  pll_fb_div,
	input wire logic        crystal_amplifier_amp_en,
	input wire logic [1:0]  prescale_code,
	input wire logic [3:0]  prescale_ratio,
	input wire logic        doubler_en,
	input wire logic [27:0] ref_freq_hz,
	input wire logic        stab_restart,
	input wire logic        irq
);
	// accepted write of the update command
	wire upd = avs_write && !avs_waitrequest && avs_byteenable[0]
		&& avs_address[11:2] == SCB_IDX_UPDATE
		&& avs_writedata[7:0] == SCB_UPD_GO;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	a_wait_one:
		assert property ((avs_read || avs_write) && avs_waitrequest
			|=> !avs_waitrequest) else $error("request not answered");
	a_wait_short:
		assert property (!avs_waitrequest |=> avs_waitrequest)
			else $error("accept held too long");
	a_idle_data:
		assert property (avs_waitrequest |-> avs_readdata == 32'h0)
			else $error("read data outside answer");
	a_resp_qual:
		assert property (avs_response != SCB_RESP_OK |-> !avs_waitrequest)
			else $error("response outside answer");
	a_pad_rsvd:
		assert property (!mp_drive_low[4]) else $error("reserved pad bit set");
	a_ratio_map:
		assert property (prescale_ratio == 4'h1 << $past(prescale_code))
			else $error("prescale ratio wrong");
	a_apply_gate:
		assert property (!upd |=> $stable({loop3_irq_mask, mp_drive_low,
			sdio_drive_low,
			pll_fb_div, crystal_amplifier_amp_en, prescale_code, doubler_en, ref_freq_hz}))
			else $error("applied value moved without update");
	a_restart_pulse:
		assert property (stab_restart |-> $past(upd))
			else $error("restart pulse without update");
	a_restart_follows:
		assert property (upd |=> stab_restart)
			else $error("update without restart pulse");
	c_update: cover property (upd);
	c_irq: cover property ($rose(irq));
	c_decerr: cover property (avs_response == SCB_RESP_DECERR);
endmodule

/* File: verification/test_scb_regs.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
module test_scb_regs;
	import scb_pkg::*;
	logic        core_clk, rst, avs_read, avs_write, sdio_drive_low;
	logic        crystal_amplifier_amp_en, doubler_en, stab_restart, irq, avs_waitrequest;
	logic [11:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable, prescale_ratio;
	logic [1:0]  avs_response, prescale_code, rsp;
	logic [7:0]  mp_drive_low, pll_fb_div, rdat;
	logic [23:0] loop3_irq_mask;
	logic [27:0] ref_freq_hz;
	int          err_count, checked;
	// register index, value written, value read back
	logic [25:0] rows [11] = '{{10'h11b, 8'hff, 8'hff},
		{10'h11c, 8'ha5, 8'ha5}, {10'h11d, 8'h5a, 8'h5a},
		{10'h11e, 8'hff, 8'hef}, {10'h11f, 8'hff, 8'h04},
		{10'h200, 8'h03, 8'h03}, {10'h201, 8'hf6, 8'h06},
		{10'h202, 8'h78, 8'h78}, {10'h203, 8'h56, 8'h56},
		{10'h204, 8'h34, 8'h34}, {10'h205, 8'hf2, 8'h02}};
	scb_regs dut (.core_clk, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.avs_response, .loop3_irq_mask, .mp_drive_low, .sdio_drive_low,
		.pll_fb_div, .crystal_amplifier_amp_en, .prescale_code, .prescale_ratio,
		.doubler_en, .ref_freq_hz, .stab_restart, .irq);
	task acc(input logic w, input logic [9:0] i, input logic [7:0] d);
		avs_write <= w;
		avs_read <= !w;
		avs_address <= {i, 2'b00};
		avs_writedata <= {24'h0, d};
		@(posedge core_clk);
		while (avs_waitrequest)
			@(posedge core_clk);
		rdat = avs_readdata[7:0];
		rsp = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
	endtask
	task chk(input logic [79:0] g, input logic [79:0] e);
		checked++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (3000) @(posedge core_clk);
		err_count++;
		results();
	end
	initial
	begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 12'h000;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		foreach (rows[k])
		begin
			acc(1'b1, rows[k][25:16], rows[k][15:8]);
			acc(1'b0, rows[k][25:16], 8'h00);
			chk(rdat, rows[k][7:0]);
		end
		acc(1'b1, SCB_IDX_UPDATE, SCB_UPD_GO);
		chk({loop3_irq_mask, mp_drive_low, sdio_drive_low, pll_fb_div,
			crystal_amplifier_amp_en, prescale_code, doubler_en, ref_freq_hz},
			{24'h5aa5ff, 8'hef, 1'b1, 8'h03, 3'b011, 1'b0, 28'h2345678});
		chk(stab_restart, 1'b1);
		for (int c = 0; c < 4; c++)
		begin
			acc(1'b1, 10'h201, {4'h0, 1'b1, c[1:0], c[0]});
			acc(1'b1, SCB_IDX_UPDATE, SCB_UPD_GO);
			@(posedge core_clk);
			chk({crystal_amplifier_amp_en, prescale_code, prescale_ratio, doubler_en},
				{1'b1, c[1:0], 4'h1 << c, c[0]});
		end
		acc(1'b0, 10'h300, 8'h00);
		chk({rsp, rdat}, {SCB_RESP_DECERR, 8'h00});
		avs_byteenable <= 4'h0;
		acc(1'b1, 10'h200, 8'hff);
		avs_byteenable <= 4'hf;
		acc(1'b0, 10'h200, 8'h00);
		chk(rdat, 8'h03);
		acc(1'b1, 10'h200, 8'h10);
		acc(1'b1, SCB_IDX_UPDATE, 8'h02);
		chk({stab_restart, pll_fb_div}, {1'b0, 8'h03});
		acc(1'b0, SCB_IDX_STATUS, 8'h00);
		chk({irq, rdat}, {1'b0, 8'h07});
		acc(1'b1, 10'h0f1, 8'h01);
		acc(1'b1, SCB_IDX_UPDATE, SCB_UPD_GO);
		@(posedge core_clk);
		chk({irq, pll_fb_div}, {1'b1, 8'h10});
		acc(1'b0, SCB_IDX_STATUS, 8'h00);
		@(posedge core_clk);
		chk({irq, rdat}, {1'b0, 8'h01});
		rst <= 1'b1;
		@(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk({avs_waitrequest, irq, crystal_amplifier_amp_en, prescale_ratio, prescale_code,
			doubler_en, mp_drive_low, sdio_drive_low, pll_fb_div,
			ref_freq_hz, loop3_irq_mask}, {3'b101, 4'h1, 2'b00, 1'b0,
			8'h00, 1'b0, 8'h00, 28'h0, 24'h0});
		acc(1'b0, 10'h201, 8'h00);
		chk(rdat, 8'h08);
		results();
	end
endmodule
bind scb_regs scb_regs_properties u_props (.core_clk, .rst, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
	.avs_waitrequest, .avs_response, .mp_drive_low, .sdio_drive_low,
	.pll_fb_div, .crystal_amplifier_amp_en, .prescale_code, .prescale_ratio,
	.doubler_en, .ref_freq_hz, .stab_restart, .irq, .loop3_irq_mask);
